// ===== include/acs_defs.svh
// constants for the conversion sequencer timing block
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

`define ACS_CONVERT_SELECT_LONG_CK    8'h2C
`define ACS_CONVERT_SELECT_SHORT_CK   8'h15
`define ACS_ACQ_6_CK        8'h06
`define ACS_ACQ_10_CK       8'h0A
`define ACS_ACQ_18_CK       8'h12
`define ACS_ACQ_34_CK       8'h22
`define ACS_DOR_MAX_SK      4'h9
`define ACS_CONVERT_SELECT_VALID_SK   4'h8
`define ACS_PWRUP_US        250
`define ACS_PD_SYNC_CK      18'h3
`define ACS_CLK_MHZ         100
`define ACS_CONVERSION_CLOCK_DIV        8'h0C
`define ACS_ONE8            8'h01
`define ACS_ONE4            4'h1

`endif

// ===== include/acs_pkg.sv
// types for the conversion sequencer timing block
`default_nettype none
package acs_pkg;

	typedef enum logic [2:0] {
		ACS_OFF  = 3'h0,
		ACS_WAKE = 3'h1,
		ACS_IDLE = 3'h3,
		ACS_ACQ  = 3'h2,
		ACS_CONVERT_SELECT = 3'h6
	} acs_state_e;

	typedef struct packed {
		logic       start;
		logic       short_res;
		logic [1:0] acq_sel;
		logic       sw_power_up;
		logic       sw_power_down;
	} acs_cmd_s;

	typedef struct packed {
		logic       end_of_convert_select;
		logic       busy;
		logic       awake;
	} acs_status_s;

endpackage : acs_pkg
`default_nettype wire

// ===== rtl/acs_edge_sync.sv
// two-flop synchroniser with edge detection for pin inputs
`default_nettype none
module acs_edge_sync (
	input  wire logic ref_clk,
	input  wire logic srst,
	input  wire logic pin,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic [2:0] sh;

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			sh <= 3'h0;
		end else begin
			sh <= {sh[1:0], pin};
		end
	end

	// sh[0] is the metastable stage; only sh[1] and sh[2] feed logic
	assign level = sh[1];
	assign rise  = sh[1] & ~sh[2];
	assign fall  = ~sh[1] & sh[2];
endmodule : acs_edge_sync
`default_nettype wire

// ===== rtl/acs_seq.sv
// conversion sequencer: conversion, acquisition, ready and power-up timing
`include "acs_defs.svh"
`default_nettype none

// Overview of operation
// RULE_01 - twelve-bit conversion completes within 44 conversion-clock periods
// RULE_02 - eight-bit conversion completes within 21 conversion-clock periods
// RULE_03 - acquisition lasts 6, 10, 18 or 34 periods, at most one more
// RULE_04 - with select held low, ready pulse stays high at most 9 serial clocks
// RULE_05 - convert-select read data valid within 8 serial clocks
// RULE_06 - after power-down pin falls, end-of-conversion rises within 250 us
// RULE_07 - after software power-up, end-of-conversion rises within 250 us
// RULE_08 - host waits for end-of-conversion after power-up before converting
module acs_seq #(
	parameter int unsigned PWRUP_CYCLES = `ACS_PWRUP_US * `ACS_CLK_MHZ
) (
	input  wire logic               ref_clk,
	input  wire logic               srst,
	input  wire logic               conversion_clock,
	input  wire logic               serial_clock,
	input  wire logic               chip_select_n,
	input  wire logic               convert_select_n,
	input  wire logic               power_down_pin,
	input  wire acs_pkg::acs_cmd_s  cmd,
	output acs_pkg::acs_status_s    status,
	output logic                    data_out_ready,
	output logic                    convert_select_data_valid
);
	typedef struct packed {
		acs_pkg::acs_state_e st;
		logic [7:0]          cnt;
		logic [7:0]          acq_len;
		logic                short_res;
		logic [17:0]         wake_cnt;
		logic                eoc;
		logic [3:0]          dor_cnt;
		logic                dor;
		logic [3:0]          cv_cnt;
		logic                cv_valid;
	} acs_regs_s;

	acs_regs_s r;
	acs_regs_s next_r;
	logic ck_rise;
	logic sk_fall;
	logic cs_low;
	logic cv_low;
	logic pd_hi;
	logic pd_fall;
	logic cv_n_lvl;

	// ====================================================================
	// pin synchronisers
	acs_edge_sync u_ck (.ref_clk(ref_clk), .srst(srst), .pin(conversion_clock),
		.level(), .rise(ck_rise), .fall());
	acs_edge_sync u_sk (.ref_clk(ref_clk), .srst(srst), .pin(serial_clock),
		.level(), .rise(), .fall(sk_fall));
	acs_edge_sync u_cs (.ref_clk(ref_clk), .srst(srst), .pin(chip_select_n),
		.level(), .rise(), .fall(cs_low));
	acs_edge_sync u_cv (.ref_clk(ref_clk), .srst(srst), .pin(convert_select_n),
		.level(cv_n_lvl), .rise(), .fall());
	// the convert-select pin is active low
	assign cv_low = ~cv_n_lvl;
	acs_edge_sync u_pd (.ref_clk(ref_clk), .srst(srst), .pin(power_down_pin),
		.level(pd_hi), .rise(), .fall(pd_fall));

	logic cs_n_lvl;
	acs_edge_sync u_csl (.ref_clk(ref_clk), .srst(srst), .pin(chip_select_n),
		.level(cs_n_lvl), .rise(), .fall());

	// ====================================================================
	// next-state logic
	always_comb begin
		next_r = r;
		case (r.st)
			acs_pkg::ACS_OFF: begin
				next_r.eoc = 1'b0;
				if (pd_fall || (!pd_hi && cmd.sw_power_up)) begin
					next_r.st       = acs_pkg::ACS_WAKE;
					// the pin fall reaches us three cycles late; credit them so eoc still meets the limit
					next_r.wake_cnt = pd_fall ? `ACS_PD_SYNC_CK : 18'h0; // RULE_06
				end
			end
			acs_pkg::ACS_WAKE: begin
				// wake time counted on ref_clk so a halted conversion clock cannot stall it
				next_r.wake_cnt = r.wake_cnt + 18'h1;
				if (32'(r.wake_cnt) >= PWRUP_CYCLES - 1) begin // RULE_06 RULE_07
					next_r.st  = acs_pkg::ACS_IDLE;
					next_r.eoc = 1'b1;
				end
			end
			acs_pkg::ACS_IDLE: begin
				// a start during wake-up is dropped; the host must wait for eoc
				if (cmd.start) begin // RULE_08
					next_r.st        = acs_pkg::ACS_ACQ;
					next_r.eoc       = 1'b0;
					next_r.cnt       = 8'h0;
					next_r.short_res = cmd.short_res;
					case (cmd.acq_sel) // RULE_03
						2'h0:    next_r.acq_len = `ACS_ACQ_6_CK;
						2'h1:    next_r.acq_len = `ACS_ACQ_10_CK;
						2'h2:    next_r.acq_len = `ACS_ACQ_18_CK;
						default: next_r.acq_len = `ACS_ACQ_34_CK;
					endcase
				end
			end
			acs_pkg::ACS_ACQ: begin
				if (ck_rise) begin
					next_r.cnt = r.cnt + `ACS_ONE8;
					// one rise past the programmed count: the period in which start lands is partial
					if (r.cnt >= r.acq_len) begin // RULE_03
						next_r.st  = acs_pkg::ACS_CONVERT_SELECT;
						next_r.cnt = 8'h0;
					end
				end
			end
			acs_pkg::ACS_CONVERT_SELECT: begin
				if (ck_rise) begin
					next_r.cnt = r.cnt + `ACS_ONE8;
					if (r.cnt + `ACS_ONE8 >= (r.short_res ? `ACS_CONVERT_SELECT_SHORT_CK
							: `ACS_CONVERT_SELECT_LONG_CK)) begin // RULE_01 RULE_02
						next_r.st  = acs_pkg::ACS_IDLE;
						next_r.eoc = 1'b1;
					end
				end
			end
			default: next_r.st = acs_pkg::ACS_OFF;
		endcase

		// power-down wins over any conversion or wake-up activity; ready and data-valid logic keep running
		if (pd_hi || cmd.sw_power_down) begin
			next_r.st  = acs_pkg::ACS_OFF;
			next_r.eoc = 1'b0;
		end

		// ready pulse: starts on select falling, ends after 9 serial clocks or when select rises
		if (cs_low) begin
			next_r.dor     = 1'b1;
			next_r.dor_cnt = 4'h0;
		end else if (r.dor && sk_fall) begin
			next_r.dor_cnt = r.dor_cnt + `ACS_ONE4;
			if (r.dor_cnt + `ACS_ONE4 >= `ACS_DOR_MAX_SK) begin // RULE_04
				next_r.dor = 1'b0;
			end
		end
		if (cs_n_lvl) begin
			next_r.dor = 1'b0;
		end

		// convert-select data validity after 8 serial clocks
		if (!cv_low) begin
			next_r.cv_cnt   = 4'h0;
			next_r.cv_valid = 1'b0;
		end else if (sk_fall && !r.cv_valid) begin
			next_r.cv_cnt = r.cv_cnt + `ACS_ONE4;
			if (r.cv_cnt + `ACS_ONE4 >= `ACS_CONVERT_SELECT_VALID_SK) begin // RULE_05
				next_r.cv_valid = 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			r    <= '0;
			r.st <= acs_pkg::ACS_OFF;
		end else begin
			r <= next_r;
		end
	end

	assign status = '{
		end_of_convert_select: r.eoc,
		busy:        (r.st == acs_pkg::ACS_ACQ) || (r.st == acs_pkg::ACS_CONVERT_SELECT),
		awake:       (r.st != acs_pkg::ACS_OFF) && (r.st != acs_pkg::ACS_WAKE)
	};
	assign data_out_ready     = r.dor;
	assign convert_select_data_valid    = r.cv_valid;

	// ====================================================================
	// assertions
	logic [7:0] ck_in_convert_select;
	always_ff @(posedge ref_clk) begin
		if (srst || r.st != acs_pkg::ACS_CONVERT_SELECT) begin
			ck_in_convert_select <= 8'h0;
		end else if (ck_rise) begin
			ck_in_convert_select <= ck_in_convert_select + `ACS_ONE8;
		end
	end

	convert_select_long_a : assert property (@(posedge ref_clk) disable iff (srst) // RULE_01
		(r.st == acs_pkg::ACS_CONVERT_SELECT && !r.short_res) |-> ck_in_convert_select < `ACS_CONVERT_SELECT_LONG_CK)
		else $error("long conversion overran");
	convert_select_short_a : assert property (@(posedge ref_clk) disable iff (srst) // RULE_02
		(r.st == acs_pkg::ACS_CONVERT_SELECT && r.short_res) |-> ck_in_convert_select < `ACS_CONVERT_SELECT_SHORT_CK)
		else $error("short conversion overran");
	acq_len_a : assert property (@(posedge ref_clk) disable iff (srst) // RULE_03
		(r.st == acs_pkg::ACS_ACQ && next_r.st == acs_pkg::ACS_CONVERT_SELECT) |-> r.cnt == r.acq_len)
		else $error("acquisition length wrong");
	dor_max_a : assert property (@(posedge ref_clk) disable iff (srst) // RULE_04
		r.dor |-> r.dor_cnt < `ACS_DOR_MAX_SK)
		else $error("ready held too long");
	cv_valid_a : assert property (@(posedge ref_clk) disable iff (srst) // RULE_05
		$rose(r.cv_valid) |-> $past(r.cv_cnt) == `ACS_CONVERT_SELECT_VALID_SK - `ACS_ONE4)
		else $error("convert data valid at wrong count");
	wake_eoc_a : assert property (@(posedge ref_clk) disable iff (srst) // RULE_06 RULE_07
		(r.st == acs_pkg::ACS_WAKE) |-> 32'(r.wake_cnt) < PWRUP_CYCLES)
		else $error("power-up exceeded");
	off_eoc_a : assert property (@(posedge ref_clk) disable iff (srst) // RULE_08
		(r.st == acs_pkg::ACS_OFF || r.st == acs_pkg::ACS_WAKE) |-> !r.eoc)
		else $error("eoc high while not awake");
	start_acq_a : assert property (@(posedge ref_clk) disable iff (srst) // RULE_03
		(r.st == acs_pkg::ACS_IDLE && cmd.start && !pd_hi && !cmd.sw_power_down)
		|=> r.st == acs_pkg::ACS_ACQ && !r.eoc)
		else $error("start not taken");

	convert_select_done_c : cover property (@(posedge ref_clk) disable iff (srst)
		r.st == acs_pkg::ACS_CONVERT_SELECT ##1 r.st == acs_pkg::ACS_IDLE);
	wake_done_c : cover property (@(posedge ref_clk) disable iff (srst) $rose(status.awake));
	dor_end_c : cover property (@(posedge ref_clk) disable iff (srst) $fell(r.dor) && !cs_n_lvl);
	cv_c : cover property (@(posedge ref_clk) disable iff (srst) $rose(r.cv_valid));
endmodule : acs_seq
`default_nettype wire

// ===== verif/acs_host.sv
// host serial port model: select, convert select and serial clock
`default_nettype none
module acs_host (
	output logic serial_clock,
	output logic chip_select_n,
	output logic convert_select_n
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		serial_clock     = 1'b0;
		chip_select_n    = 1'b1;
		convert_select_n = 1'b1;
	end
	// ==========================================================
	// frame tasks
	task automatic open_frame(input logic convert_select);
		chip_select_n    = 1'b0;
		convert_select_n = ~convert_select;
		#40;
	endtask : open_frame
	// the clock stands still outside frames; one call may stop short of the data-valid count
	task automatic pulses(input int n);
		repeat (n) begin
			#80 serial_clock = 1'b1;
			#80 serial_clock = 1'b0;
		end
		#40;
	endtask : pulses
	task automatic close_frame();
		chip_select_n    = 1'b1;
		convert_select_n = 1'b1;
		#40;
	endtask : close_frame
endmodule : acs_host
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the conversion sequencer
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int unsigned PWR    = 50;
	localparam int          ACQ[4] = '{6, 10, 18, 34};
	typedef struct {bit kind; int val;} acs_tb_exp_s;
	logic                 ref_clk, srst, conversion_clock, power_down_pin, mark, eoc_q, ck_q;
	logic                 serial_clock, chip_select_n, convert_select_n, data_out_ready, convert_select_data_valid;
	acs_pkg::acs_cmd_s    cmd;
	acs_pkg::acs_status_s status;
	int                   fail_count, checked, n_ref, n_ck;
	logic [15:0]          lfsr;
	logic [2:0]           v;
	acs_tb_exp_s          q[$];
	acs_tb_exp_s          e;
	acs_host host (.serial_clock(serial_clock), .chip_select_n(chip_select_n),
		.convert_select_n(convert_select_n));
	acs_seq #(.PWRUP_CYCLES(PWR)) dut (.ref_clk(ref_clk), .srst(srst), .conversion_clock(conversion_clock),
		.serial_clock(serial_clock), .chip_select_n(chip_select_n), .convert_select_n(convert_select_n),
		.power_down_pin(power_down_pin), .cmd(cmd), .status(status), .data_out_ready(data_out_ready),
		.convert_select_data_valid(convert_select_data_valid));
	// ==========================================================
	// clocks and helpers
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// conversion clock phase is unrelated to ref_clk
	initial begin
		conversion_clock = 1'b0;
		#3;
		forever #40 conversion_clock = ~conversion_clock;
	end
	task automatic tick();
		@(posedge ref_clk);
		#1;
	endtask : tick
	task automatic chk_range(input int got, input int lo, input int hi, input string what);
		checked++;
		if (got < lo || got > hi) begin
			fail_count++;
			$display("[FAIL] %0t %s: %0d outside %0d..%0d", $time, what, got, lo, hi);
		end
	endtask : chk_range
	task automatic chk_bit(input logic got, input logic exp, input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s: got %b", $time, what, got);
		end
	endtask : chk_bit
	task automatic wait_eoc();
		int k;
		for (k = 0; k < 5000 && status.end_of_convert_select !== 1'b1; k++) tick();
		if (k == 5000) begin
			fail_count++;
			$display("[FAIL] %0t end of conversion never rose", $time);
		end
		repeat (2) tick();
	endtask : wait_eoc
	task automatic finish_test();
		if (fail_count == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : finish_test
	// ==========================================================
	// monitor: counts from each mark, compares at every end-of-conversion rise
	always @(posedge ref_clk) begin
		ck_q  <= conversion_clock;
		eoc_q <= status.end_of_convert_select;
		n_ref <= mark ? 0 : n_ref + 1;
		n_ck  <= mark ? 0 : n_ck + int'(conversion_clock & ~ck_q);
		if (status.end_of_convert_select === 1'b1 && eoc_q !== 1'b1 && q.size() > 0) begin
			e = q.pop_front();
			if (e.kind)
				chk_range(n_ck, e.val, e.val + 1, "conversion length");
			else
				chk_range(n_ref, PWR - 4, e.val, "power-up time");
		end
	end
	initial begin
		#300000;
		fail_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		finish_test();
	end
	// ==========================================================
	// main sequence
	initial begin
		srst = 1'b1; cmd = '0; power_down_pin = 1'b0; mark = 1'b0;
		fail_count = 0; checked = 0; lfsr = 16'h9D58;
		repeat (8) tick();
		srst = 1'b0;
		tick();
		chk_bit(status.end_of_convert_select, 1'b0, "eoc after reset");
		q.push_back('{1'b0, PWR});
		mark = 1'b1; cmd.sw_power_up = 1'b1;
		tick();
		mark = 1'b0; cmd.sw_power_up = 1'b0;
		wait_eoc();
		chk_bit(status.awake, 1'b1, "awake after wake");
		for (int i = 0; i < 10; i++) begin
			v    = (i < 8) ? 3'(i) : lfsr[2:0];
			lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
			q.push_back('{1'b1, ACQ[v[1:0]] + (v[2] ? 21 : 44)});
			mark = 1'b1; cmd.start = 1'b1; cmd.short_res = v[2]; cmd.acq_sel = v[1:0];
			tick();
			mark = 1'b0;
			// second start while busy must be ignored; the count above must still hold
			tick();
			cmd.start = 1'b0;
			chk_bit(status.busy, 1'b1, "busy");
			wait_eoc();
		end
		host.open_frame(1'b1);
		chk_bit(data_out_ready, 1'b1, "ready at select");
		host.pulses(7);
		chk_bit(convert_select_data_valid, 1'b0, "valid early");
		host.pulses(1);
		chk_bit(convert_select_data_valid, 1'b1, "valid at 8");
		host.pulses(1);
		chk_bit(data_out_ready, 1'b0, "ready after 9");
		host.close_frame();
		cmd.sw_power_down = 1'b1;
		tick();
		cmd.sw_power_down = 1'b0;
		repeat (4) tick();
		chk_bit(status.awake, 1'b0, "asleep");
		power_down_pin = 1'b1;
		repeat (6) tick();
		q.push_back('{1'b0, PWR});
		power_down_pin = 1'b0; mark = 1'b1;
		tick();
		mark = 1'b0;
		wait_eoc();
		finish_test();
	end
endmodule : tb
`default_nettype wire
